// ===== qir_pkg.sv
// Package for the quadrature index reset block
// Assumes a single 50 MHz clock domain and an AXI4-Lite register bus
package qir_pkg;
	// ********************************************************************
	// Register byte offsets
	// ********************************************************************
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_COUNT   = 8'h08;
	localparam logic [7:0] ADDR_LIMIT   = 8'h0c;
	localparam logic [7:0] ADDR_IRQ     = 8'h10;
	localparam logic [7:0] ADDR_MASK    = 8'h14;
	// ********************************************************************
	// Control fields
	// ********************************************************************
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_ENABLE   = 2;
	localparam int CTL_QSEL_LSB = 4;
	localparam int CTL_ERRATUM  = 6;
	localparam logic [1:0] MODE_RESET_ON_INDEX = 2'h0;
	localparam logic [1:0] MODE_INIT_ON_INDEX  = 2'h1;
	localparam logic [1:0] QSEL_SYNC           = 2'h0;
	localparam logic [1:0] QSEL_ASYNC          = 2'h3;
	localparam logic [31:0] CONTROL_RESET      = 32'h0000_0000;
	// ********************************************************************
	// Status and interrupt bits
	// ********************************************************************
	localparam int ST_FIRST_SEEN = 0;
	localparam int ST_FIRST_DIR  = 1;
	localparam int ST_DIR        = 2;
	localparam int ST_WAITING    = 3;
	localparam int EV_INDEX      = 0;
	localparam int EV_PHASE_ERR  = 1;
	localparam int EV_DIR_IN_IDX = 2;
	localparam int EV_WIDTH      = 3;
	localparam logic [31:0] LIMIT_RESET = 32'hffff_ffff;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== qir_decoder.sv
// Quadrature decoder with index reset of the position counter
// Synchronises raw encoder inputs itself, per pin-qualify setting
//
// Functional notes
// - Mode 00 forward index clears count
// - Mode 00 reverse index loads limit
// - Flag first index marker since configured
// - Capture direction at first index
// - Reuse first-index quadrature edge for resets
// - Reversal during index waits remembered edge
// - Next clean index resets correctly again
// - Index-init mode free of reversal fault
// - Pin qualify select resets to synchronous
`timescale 1ns/100ps
module qir_decoder #(
	parameter int CNT_W = 32
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              enc_a,
	input  wire logic              enc_b,
	input  wire logic              enc_index,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   irq
);
	// ********************************************************************
	// Input synchronisers
	// ********************************************************************
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] pin_stage;
	logic [2:0] pin_qual;
	logic [1:0] prev_ab;
	logic       prev_idx;
	logic [31:0] decoder_control;
	logic [1:0]  pin_qualify_select;
	// Async selection skips the qualify stage; pins still pass two flops
	always_ff @(posedge aclk) begin
		sync1     <= {enc_index, enc_b, enc_a};
		sync2     <= sync1;
		pin_stage <= sync2;
	end
	always_comb begin
		if (pin_qualify_select == qir_pkg::QSEL_ASYNC) begin
			pin_qual = sync2;
		end else begin
			pin_qual = pin_stage;
		end
	end
	// ********************************************************************
	// Quadrature decode
	// ********************************************************************
	logic       step;
	logic       fwd;
	logic       phase_err;
	logic       idx_rise;
	always_comb begin
		step      = 1'b0;
		fwd       = 1'b0;
		phase_err = 1'b0;
		idx_rise  = pin_qual[2] & ~prev_idx;
		if (pin_qual[1:0] != prev_ab) begin
			if (pin_qual[1:0] == ~prev_ab) begin
				phase_err = 1'b1;
			end else begin
				step = 1'b1;
				// A leads B when new A differs from old B
				fwd  = pin_qual[0] ^ prev_ab[1];
			end
		end
	end
	// ********************************************************************
	// Position counter and index logic
	// ********************************************************************
	logic [CNT_W-1:0] position_count;
	logic [CNT_W-1:0] next_position_count;
	logic [CNT_W-1:0] position_limit;
	logic             first_index_seen;
	logic             next_first_index_seen;
	logic             first_index_direction;
	logic             next_first_index_direction;
	logic             dir;
	logic             next_dir;
	logic [1:0]       ref_ab;
	logic [1:0]       next_ref_ab;
	logic             waiting;
	logic             next_waiting;
	logic             wait_dir;
	logic             next_wait_dir;
	logic             idx_evt;
	logic             dir_in_idx;
	logic [1:0]       mode;
	logic             enabled;
	logic             erratum;
	assign mode    = decoder_control[qir_pkg::CTL_MODE_LSB +: 2];
	assign enabled = decoder_control[qir_pkg::CTL_ENABLE];
	assign erratum = decoder_control[qir_pkg::CTL_ERRATUM];
	always_comb begin
		next_position_count        = position_count;
		next_first_index_seen      = first_index_seen;
		next_first_index_direction = first_index_direction;
		next_dir                   = dir;
		next_ref_ab                = ref_ab;
		next_waiting               = waiting;
		next_wait_dir              = wait_dir;
		idx_evt                    = 1'b0;
		dir_in_idx                 = 1'b0;
		if (enabled) begin
			if (step) begin
				next_dir = fwd;
				if (fwd) begin
					next_position_count = position_count + {{(CNT_W-1){1'b0}}, 1'b1};
				end else begin
					next_position_count = position_count - {{(CNT_W-1){1'b0}}, 1'b1};
				end
				dir_in_idx = pin_qual[2] && (fwd != dir);
			end
			if (mode == qir_pkg::MODE_INIT_ON_INDEX) begin
				// Plain rising-edge init; no edge matching, so no reversal fault
				if (idx_rise) begin
					idx_evt = 1'b1;
					next_position_count = '0;
					if (!first_index_seen) begin
						next_first_index_seen      = 1'b1;
						next_first_index_direction = dir;
					end
				end
			end else if (mode == qir_pkg::MODE_RESET_ON_INDEX) begin
				if (!first_index_seen && pin_qual[2] && step) begin
					// First marker: remember edge and direction
					next_first_index_seen      = 1'b1;
					next_first_index_direction = fwd;
					next_ref_ab                = pin_qual[1:0];
					idx_evt                    = 1'b1;
					next_position_count        = fwd ? '0 : position_limit;
				end else if (first_index_seen) begin
					if (idx_rise) begin
						next_waiting  = 1'b1;
						next_wait_dir = dir;
					end
					// Reversal: silicon-faithful mode keeps waiting for old edge
					if (dir_in_idx && !erratum) begin
						next_wait_dir = fwd;
					end
					if ((waiting || idx_rise) && pin_qual[2] && step && pin_qual[1:0] == ref_ab) begin
						idx_evt      = 1'b1;
						next_waiting = 1'b0;
						// Faulty model uses direction from before the index edge
						if (erratum ? (idx_rise ? dir : wait_dir) : fwd) begin
							next_position_count = '0;
						end else begin
							next_position_count = position_limit;
						end
					end
					if (!pin_qual[2]) begin
						next_waiting = 1'b0; // Clean next index starts afresh
					end
				end
			end
		end else begin
			next_first_index_seen = 1'b0;
			next_waiting          = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			position_count        <= '0;
			first_index_seen      <= 1'b0;
			first_index_direction <= 1'b0;
			dir                   <= 1'b1;
			ref_ab                <= 2'h0;
			waiting               <= 1'b0;
			wait_dir              <= 1'b0;
			prev_ab               <= 2'h0;
			prev_idx              <= 1'b0;
		end else begin
			position_count        <= next_position_count;
			first_index_seen      <= next_first_index_seen;
			first_index_direction <= next_first_index_direction;
			dir                   <= next_dir;
			ref_ab                <= next_ref_ab;
			waiting               <= next_waiting;
			wait_dir              <= next_wait_dir;
			prev_ab               <= pin_qual[1:0];
			prev_idx              <= pin_qual[2];
		end
	end
	// ********************************************************************
	// AXI4-Lite slave and interrupts
	// ********************************************************************
	localparam int EV_W = qir_pkg::EV_WIDTH;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic [EV_W-1:0] events;
	logic            wr_ask;
	logic            rd_ask;
	logic            wr_go;
	logic            rd_go;
	logic [31:0]     rd_word;
	logic            wr_ok;
	logic            rd_ok;
	assign events = {dir_in_idx, phase_err & enabled, idx_evt};
	assign pin_qualify_select = decoder_control[qir_pkg::CTL_QSEL_LSB +: 2];
	// Ready rises a cycle after valid; the item moves when both are high
	assign wr_ask = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	assign rd_ask = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	assign wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign rd_go  = s_axi_arvalid && s_axi_arready;
	always_comb begin
		rd_ok   = 1'b1;
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			qir_pkg::ADDR_CONTROL: rd_word = decoder_control;
			qir_pkg::ADDR_STATUS: rd_word = {28'h0000000, waiting, dir,
				first_index_direction, first_index_seen};
			qir_pkg::ADDR_COUNT: rd_word = 32'(position_count);
			qir_pkg::ADDR_LIMIT: rd_word = 32'(position_limit);
			qir_pkg::ADDR_IRQ: rd_word = 32'(irq_status);
			qir_pkg::ADDR_MASK: rd_word = 32'(irq_mask);
			default: rd_ok = 1'b0;
		endcase
		case (s_axi_awaddr)
			qir_pkg::ADDR_CONTROL, qir_pkg::ADDR_LIMIT,
			qir_pkg::ADDR_IRQ, qir_pkg::ADDR_MASK: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			decoder_control <= qir_pkg::CONTROL_RESET; // Sync pin mode at reset
			position_limit  <= CNT_W'(qir_pkg::LIMIT_RESET);
			irq_status      <= '0;
			irq_mask        <= '0;
			irq             <= 1'b0;
			s_axi_awready   <= 1'b0;
			s_axi_wready    <= 1'b0;
			s_axi_bvalid    <= 1'b0;
			s_axi_bresp     <= qir_pkg::RESP_OKAY;
			s_axi_arready   <= 1'b0;
			s_axi_rvalid    <= 1'b0;
			s_axi_rdata     <= 32'h0000_0000;
			s_axi_rresp     <= qir_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= wr_ask;
			s_axi_wready  <= wr_ask;
			s_axi_arready <= rd_ask;
			// Set wins over write-one-to-clear
			if (wr_go && s_axi_awaddr == qir_pkg::ADDR_IRQ && s_axi_wstrb[0]) begin
				irq_status <= (irq_status & ~s_axi_wdata[EV_W-1:0]) | events;
			end else begin
				irq_status <= irq_status | events;
			end
			irq <= |(irq_status & irq_mask);
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? qir_pkg::RESP_OKAY : qir_pkg::RESP_SLVERR;
				if (s_axi_awaddr == qir_pkg::ADDR_CONTROL && s_axi_wstrb[0]) begin
					decoder_control[7:0] <= s_axi_wdata[7:0];
				end
				if (s_axi_awaddr == qir_pkg::ADDR_LIMIT) begin
					position_limit <= s_axi_wdata[CNT_W-1:0];
				end
				if (s_axi_awaddr == qir_pkg::ADDR_MASK && s_axi_wstrb[0]) begin
					irq_mask <= s_axi_wdata[EV_W-1:0];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? qir_pkg::RESP_OKAY : qir_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ===== qir_props.sv
// Checker for the decoder register bus handshake
// Assumes a bind to qir_decoder, one clock, sync active-low reset
`timescale 1ns/100ps
module qir_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	// ****************************************
	// Bus timing
	// ****************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_write_taken: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
		&& !s_axi_awready |=> s_axi_awready && s_axi_wready)
		else $error("write not answered");
	a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid) else $error("write response missing");
	a_read_taken: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
		|=> s_axi_arready) else $error("read not answered");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read data missing");
	a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
	a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("response repeated");
	a_rvalid_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready too long");
	a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == qir_pkg::RESP_OKAY
		|| s_axi_bresp == qir_pkg::RESP_SLVERR) else $error("odd response code");
endmodule
bind qir_decoder qir_props u_qir_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ===== qir_encoder.sv
// Far-side model: quadrature encoder with one index state
// Assumes the bench calls step right after a clock edge
`timescale 1ns/100ps
module qir_encoder (
	input  wire logic aclk,
	output logic      enc_a,
	output logic      enc_b,
	output logic      enc_index
);
	// ****************************************
	// Shaft
	// ****************************************
	int pos = -40;
	// Gray order, A leads B forward
	assign enc_a = pos[1] ^ pos[0];
	assign enc_b = pos[1];
	// Index tied to angle, so reversals hit it
	assign enc_index = (pos == 0);
	// Moves land on the edge, pins stay synchronous
	task automatic step(input logic fwd, input int gap);
		repeat (gap) @(posedge aclk);
		pos <= fwd ? pos + 1 : pos - 1;
	endtask
endmodule

// ===== qir_decoder_test.sv
// Bench for the decoder: bus tasks and scripted shaft moves
// Assumes qir_encoder on the pins and qir_props bound in
`timescale 1ns/100ps
module qir_decoder_test;
	localparam logic [1:0] OK = qir_pkg::RESP_OKAY;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq, ea, eb, ei;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, v, base;
	int          errors = 0;
	int          checks_done = 0;
	always #10 aclk = ~aclk;
	qir_encoder u_qir_encoder (.aclk(aclk), .enc_a(ea), .enc_b(eb), .enc_index(ei));
	qir_decoder u_qir_decoder (.aclk(aclk), .aresetn(aresetn), .enc_a(ea), .enc_b(eb),
		.enc_index(ei), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, r});
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rready <= 1'b0;
		d = rdata;
		chk({30'h0, rresp}, {30'h0, r});
		@(posedge aclk);
	endtask
	task automatic see(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, OK, v);
		chk(v & m, e);
	endtask
	// Count settles a few cycles after the last step, well before the read
	task automatic cnt(input logic [31:0] e);
		rd(qir_pkg::ADDR_COUNT, OK, v);
		chk(v, e);
	endtask
	task automatic mv(input logic f, input int n);
		repeat (n) u_qir_encoder.step(f, 4);
		repeat (6) @(posedge aclk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Run needs about 630 cycles
	initial begin
		#400000;
		errors++;
		tally_and_finish;
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		see(qir_pkg::ADDR_CONTROL, '1, qir_pkg::CONTROL_RESET);
		see(qir_pkg::ADDR_LIMIT, '1, qir_pkg::LIMIT_RESET);
		wr(qir_pkg::ADDR_CONTROL, 32'h5, OK);
		rd(qir_pkg::ADDR_COUNT, OK, base);
		mv(1'b1, 6);
		cnt(base + 32'h6);
		mv(1'b0, 2);
		cnt(base + 32'h4);
		mv(1'b1, 36);
		mv(1'b0, 1);
		cnt(32'hffff_ffff);
		mv(1'b1, 6);
		cnt(32'h5);
		see(qir_pkg::ADDR_STATUS, 32'h1, 32'h1);
		wr(qir_pkg::ADDR_CONTROL, 32'h0, OK);
		see(qir_pkg::ADDR_STATUS, 32'h1, 32'h0);
		$display("test counting done");
		wr(qir_pkg::ADDR_LIMIT, 32'h3e7, OK);
		wr(qir_pkg::ADDR_CONTROL, 32'h4, OK);
		mv(1'b0, 8);
		cnt(32'h3e4);
		rd(qir_pkg::ADDR_STATUS, OK, v);
		chk({31'h0, v[1] ^ v[2]}, 32'h0);
		mv(1'b1, 10);
		cnt(32'h7);
		rd(qir_pkg::ADDR_STATUS, OK, v);
		chk({31'h0, v[1] ^ v[2]}, 32'h1);
		see(qir_pkg::ADDR_IRQ, 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(qir_pkg::ADDR_MASK, 32'h1, OK);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(qir_pkg::ADDR_IRQ, 32'h7, OK);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		$display("test index reset done");
		wr(qir_pkg::ADDR_CONTROL, 32'h44, OK);
		mv(1'b0, 7);
		cnt(32'h3e7);
		mv(1'b1, 1);
		mv(1'b0, 1);
		see(qir_pkg::ADDR_IRQ, 32'h4, 32'h4);
		cnt(32'h0);
		mv(1'b0, 6);
		cnt(32'hffff_fffa);
		mv(1'b1, 12);
		cnt(32'h6);
		mv(1'b0, 7);
		cnt(32'h3e6);
		wr(qir_pkg::ADDR_CONTROL, 32'h4, OK);
		mv(1'b1, 1);
		cnt(32'h0);
		rd(8'h20, qir_pkg::RESP_SLVERR, v);
		chk(v, 32'h0);
		wr(qir_pkg::ADDR_COUNT, 32'h0, qir_pkg::RESP_SLVERR);
		$display("test reversal done");
		tally_and_finish;
	end
endmodule
